// ===== src/init_timing_cfg.svh
// Offsets, field positions, reset values and timing counts for the init/timing block
`ifndef INIT_TIMING_CFG_SVH
`define INIT_TIMING_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_OWN_STATION 8'h04
`define OFS_PROBE_NODE 8'h08
`define OFS_COLLISION_NODE 8'h0C
`define OFS_SUCCESSOR_NODE 8'h10
`define OFS_REVISION 8'h14
`define OFS_COMMAND 8'h18
`define OFS_STATUS 8'h1C
`define OFS_MASK 8'h20
`define OFS_RAM0 8'h24
`define OFS_RAM1 8'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_SYNC_WAIT_BYPASS 0
`define CTL_ENHANCED_TIMING 1
`define CTL_SOFT_RESET 2
`define CTL_PRESCALE_LSB 4
`define CTL_PRESCALE_MSB 6
`define ST_TA 0
`define ST_RI 1
`define ST_CMD_REFUSED 2
`define ST_PROBE_ANSWERED 3
`define ST_INIT_DONE 4

// ----------------------------------------------------------------------
// Reset values, patterns and command codes
// ----------------------------------------------------------------------
`define CONTROL_RESET 8'h00
`define INIT_PATTERN 8'hD1
`define INIT_ADDR0 11'h000
`define INIT_ADDR1 11'h001
`define CMD_CLEAR_TXRX_INT 8'h01
`define CMD_CLEAR_FLAG 8'h02
`define CMD_ENABLE_TX 8'h03
`define CMD_ENABLE_RX 8'h04

// ----------------------------------------------------------------------
// Timing: figures as printed, cycle counts derived from the clock period
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define INT_DISABLE_MIN_NS 200
`define INT_DISABLE_CYC ((`INT_DISABLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define CMD_SPACE_EF_NS 100
`define CMD_SPACE_EF_CYC ((`CMD_SPACE_EF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_SPACE_OS_TICKS 2
`define INT_DISABLE_OS_TICKS 2
`define OS_DIV_BASE 8

`endif

// ===== src/init_timing_pkg.sv
// Types shared by the init/timing block
package init_timing_pkg;

  // Start-up micro-program states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SYNC = 3'b001,
    ST_WR0 = 3'b010,
    ST_WR1 = 3'b011,
    ST_DONE = 3'b100
  } init_state_t;

  // Latched AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_phase_t;

  // RAM write port
  typedef struct packed {
    logic we;
    logic [10:0] addr;
    logic [7:0] data;
  } ram_wr_t;

endpackage

// ===== src/init_and_timing_refinements.sv
// Start-up RAM init, enhanced-timing refinements and revision check with AHB-Lite registers
//
// Functional notes
// - Bypass clear: init write waits for idle line
// - Own-station write stores D1 then ID
// - Line-idle wait stalls init RAM writes
// - Bypass set: suppress wait inside init routine
// - Enhanced bit clear keeps legacy timing
// - Clear commands or successor read deassert interrupt
// - Enhanced: interrupt disable exceeds 200 ns
// - Prescale select field picks data rate
// - Enhanced: prescale select synchronised to prescaler
// - Legacy command spacing from oversample clock
// - Enhanced command spacing 100 ns
// - Legacy: enable commands refused during pulse
// - Enhanced: flags rise at pulse end
// - Enhanced: probe/own writes clear stale IDs
// - Enhanced: soft reset clears mask
// - Own-station zero or reset bit soft-resets
// - Soft reset sets TA and RI flags
// - Revision register readback identifies silicon
`timescale 1ns/10ps
`include "init_timing_cfg.svh"

module init_and_timing_refinements #(
  parameter logic [7:0] REVISION_ID = 8'hC5 // Arbitrary value, upper bits set
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_line_idle,
  input wire logic i_ta_set_pulse,
  input wire logic i_ri_set_pulse,
  input wire logic [7:0] i_successor_node,
  input wire logic i_collision_valid,
  input wire logic [7:0] i_collision_id,
  input wire logic i_probe_answer,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_interrupt_out_n,
  output init_timing_pkg::ram_wr_t o_ram_wr,
  output logic o_oversample_clock,
  output logic [7:0] o_own_station,
  output logic [7:0] o_probe_node,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code
);
  import init_timing_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ahb_phase_t dphase;
  init_state_t state;
  logic sync_wait_bypass;
  logic enhanced_timing_enable;
  logic soft_reset_bit;
  logic [2:0] clock_prescale_select;
  logic [2:0] prescale_eff;
  logic [7:0] own_station;
  logic [7:0] probe_node;
  logic [7:0] collision_node;
  logic [7:0] mask;
  logic [1:0] rev_bits;
  logic [7:0] ram0;
  logic [7:0] ram1;
  logic transmitter_available_flag;
  logic receiver_inhibited_flag;
  logic cmd_refused;
  logic probe_answered;
  logic ta_pulse_d;
  logic ri_pulse_d;
  logic [10:0] os_cnt;
  logic os_tick;
  logic [3:0] int_block;
  logic [3:0] cmd_gap;
  logic wr_en;
  logic rd_en;
  logic soft_rst;
  logic own_wr;
  logic probe_wr;
  logic cmd_wr;
  logic cmd_ok;
  logic int_clear;
  logic [7:0] wbyte;
  logic [10:0] os_div;
  logic in_init;
  logic sync_stall;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Address phase accepted on NONSEQ or SEQ with hready
  assign rd_en = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  assign wr_en = dphase.valid && dphase.write;
  assign wbyte = i_hwdata[7:0];
  assign own_wr = wr_en && (dphase.addr == `OFS_OWN_STATION);
  assign probe_wr = wr_en && (dphase.addr == `OFS_PROBE_NODE);
  assign cmd_wr = wr_en && (dphase.addr == `OFS_COMMAND);
  assign cmd_ok = (cmd_gap == 4'h0)
                  && !(!enhanced_timing_enable && (i_ta_set_pulse || i_ri_set_pulse)
                       && ((wbyte == `CMD_ENABLE_TX) || (wbyte == `CMD_ENABLE_RX)));
  assign int_clear = (cmd_wr && cmd_ok && ((wbyte == `CMD_CLEAR_TXRX_INT)
                      || (wbyte == `CMD_CLEAR_FLAG)))
                     || (rd_en && (i_haddr[7:0] == `OFS_SUCCESSOR_NODE));
  assign soft_rst = soft_reset_bit || (own_wr && (wbyte == 8'h00));

  // Latch address phase for the following data phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dphase <= '0;
    end else if (i_hready) begin
      dphase.valid <= i_hsel && i_htrans[1];
      dphase.write <= i_hwrite;
      dphase.addr <= {i_haddr[7:2], 2'b00};
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (i_haddr[7:0])
        `OFS_CONTROL: o_hrdata <= {25'h0, clock_prescale_select, 1'b0, soft_reset_bit,
                                   enhanced_timing_enable, sync_wait_bypass};
        `OFS_OWN_STATION: o_hrdata <= {24'h0, own_station};
        `OFS_PROBE_NODE: o_hrdata <= {24'h0, probe_node};
        `OFS_COLLISION_NODE: o_hrdata <= {24'h0, collision_node};
        `OFS_SUCCESSOR_NODE: o_hrdata <= {24'h0, i_successor_node};
        `OFS_REVISION: o_hrdata <= (rev_bits == 2'b11) ? {24'h0, REVISION_ID}
                                   : {24'h0, rev_bits, 6'h00};
        `OFS_STATUS: o_hrdata <= {27'h0, (state == ST_DONE), probe_answered, cmd_refused,
                                  receiver_inhibited_flag, transmitter_available_flag};
        `OFS_MASK: o_hrdata <= {24'h0, mask};
        `OFS_RAM0: o_hrdata <= {24'h0, ram0};
        `OFS_RAM1: o_hrdata <= {24'h0, ram1};
        default: o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Control bits, hard reset to legacy behaviour
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_wait_bypass <= 1'b0;
      enhanced_timing_enable <= 1'b0;
      soft_reset_bit <= 1'b0;
      clock_prescale_select <= 3'h0;
    end else if (wr_en && (dphase.addr == `OFS_CONTROL)) begin
      sync_wait_bypass <= wbyte[`CTL_SYNC_WAIT_BYPASS];
      enhanced_timing_enable <= wbyte[`CTL_ENHANCED_TIMING];
      soft_reset_bit <= wbyte[`CTL_SOFT_RESET];
      clock_prescale_select <= wbyte[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB];
    end
  end

  // Station, probe and revision registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      own_station <= 8'h00;
      probe_node <= 8'h00;
      rev_bits <= 2'b00;
    end else begin
      if (own_wr) begin
        own_station <= wbyte;
      end
      if (probe_wr) begin
        probe_node <= wbyte;
      end
      if (wr_en && (dphase.addr == `OFS_REVISION)) begin
        rev_bits <= wbyte[7:6];
      end
    end
  end

  // Collision ID and probe answer; stale values cleared on ID writes when enhanced, and on soft reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      collision_node <= 8'h00;
      probe_answered <= 1'b0;
    end else if (i_collision_valid || i_probe_answer) begin
      if (i_collision_valid) begin
        collision_node <= i_collision_id;
      end
      if (i_probe_answer) begin
        probe_answered <= 1'b1;
      end
    end else if (soft_rst || (enhanced_timing_enable && (own_wr || probe_wr))) begin
      collision_node <= 8'h00;
      probe_answered <= 1'b0;
    end else if (cmd_wr && cmd_ok && (wbyte == `CMD_CLEAR_FLAG)) begin
      probe_answered <= 1'b0;
    end
  end

  // Interrupt mask; soft reset clears it only with enhanced timing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask <= 8'h00;
    end else if (soft_rst && enhanced_timing_enable) begin
      mask <= 8'h00;
    end else if (wr_en && (dphase.addr == `OFS_MASK)) begin
      mask <= wbyte;
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  // Select taken at prescaler wrap when enhanced, raw otherwise
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_eff <= 3'h0;
    end else if (!enhanced_timing_enable || os_tick) begin
      prescale_eff <= clock_prescale_select;
    end
  end

  assign os_div = 11'(`OS_DIV_BASE) << prescale_eff;
  assign os_tick = (os_cnt >= os_div - 11'h001);

  // Oversample counter and clock output
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      os_cnt <= 11'h000;
      o_oversample_clock <= 1'b0;
    end else if (os_tick) begin
      os_cnt <= 11'h000;
      o_oversample_clock <= ~o_oversample_clock;
    end else begin
      os_cnt <= os_cnt + 11'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Command spacing
  // ----------------------------------------------------------------------
  // Gap counter: crystal cycles when enhanced, oversample ticks otherwise
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_gap <= 4'h0;
    end else if (cmd_wr && cmd_ok) begin
      cmd_gap <= enhanced_timing_enable ? 4'(`CMD_SPACE_EF_CYC)
                                        : 4'(`CMD_SPACE_OS_TICKS);
    end else if ((cmd_gap != 4'h0) && (enhanced_timing_enable || os_tick)) begin
      cmd_gap <= cmd_gap - 4'h1;
    end
  end

  // Accepted command strobe and refused sticky bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd_code <= 8'h00;
      cmd_refused <= 1'b0;
    end else begin
      o_cmd_valid <= cmd_wr && cmd_ok;
      if (cmd_wr && cmd_ok) begin
        o_cmd_code <= wbyte;
      end
      if (cmd_wr && !cmd_ok) begin
        cmd_refused <= 1'b1;
      end else if (rd_en && (i_haddr[7:0] == `OFS_STATUS)) begin
        cmd_refused <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  // Flags rise at pulse start (legacy) or pulse end (enhanced)
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ta_pulse_d <= 1'b0;
      ri_pulse_d <= 1'b0;
      transmitter_available_flag <= 1'b1;
      receiver_inhibited_flag <= 1'b1;
    end else begin
      ta_pulse_d <= i_ta_set_pulse;
      ri_pulse_d <= i_ri_set_pulse;
      if (soft_rst || (enhanced_timing_enable ? (ta_pulse_d && !i_ta_set_pulse)
                       : (i_ta_set_pulse && !ta_pulse_d))) begin
        transmitter_available_flag <= 1'b1;
      end else if (cmd_wr && cmd_ok && (wbyte == `CMD_ENABLE_TX)) begin
        transmitter_available_flag <= 1'b0;
      end
      if (soft_rst || (enhanced_timing_enable ? (ri_pulse_d && !i_ri_set_pulse)
                       : (i_ri_set_pulse && !ri_pulse_d))) begin
        receiver_inhibited_flag <= 1'b1;
      end else if (cmd_wr && cmd_ok && (wbyte == `CMD_ENABLE_RX)) begin
        receiver_inhibited_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Disable window after a clear; length independent of rate when enhanced
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_block <= 4'h0;
    end else if (int_clear && !o_interrupt_out_n) begin
      int_block <= enhanced_timing_enable ? 4'(`INT_DISABLE_CYC)
                                          : 4'(`INT_DISABLE_OS_TICKS);
    end else if ((int_block != 4'h0) && (enhanced_timing_enable || os_tick)) begin
      int_block <= int_block - 4'h1;
    end
  end

  // Active-low interrupt from masked flags
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_interrupt_out_n <= 1'b1;
    end else if ((int_clear && !o_interrupt_out_n) || (int_block != 4'h0)) begin
      o_interrupt_out_n <= 1'b1;
    end else begin
      o_interrupt_out_n <= !((mask[`ST_TA] && transmitter_available_flag)
                             || (mask[`ST_RI] && receiver_inhibited_flag)
                             || (mask[`ST_PROBE_ANSWERED] && probe_answered));
    end
  end

  // ----------------------------------------------------------------------
  // Start-up micro-program
  // ----------------------------------------------------------------------
  // Wait suppressed while the program counter decodes as init routine
  assign in_init = (state == ST_SYNC) || (state == ST_WR0) || (state == ST_WR1);
  assign sync_stall = !i_line_idle && !(sync_wait_bypass && in_init);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else if (own_wr && (wbyte != 8'h00)) begin
      state <= ST_SYNC;
    end else begin
      case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_SYNC: state <= sync_stall ? ST_SYNC : ST_WR0;
        ST_WR0: state <= ST_WR1;
        ST_WR1: state <= ST_DONE;
        ST_DONE: state <= ST_DONE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // RAM writes of pattern and station ID
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ram_wr <= '0;
      ram0 <= 8'h00;
      ram1 <= 8'h00;
    end else begin
      o_ram_wr.we <= (state == ST_WR0) || (state == ST_WR1);
      if (state == ST_WR0) begin
        o_ram_wr.addr <= `INIT_ADDR0;
        o_ram_wr.data <= `INIT_PATTERN;
        ram0 <= `INIT_PATTERN;
      end else if (state == ST_WR1) begin
        o_ram_wr.addr <= `INIT_ADDR1;
        o_ram_wr.data <= own_station;
        ram1 <= own_station;
      end
    end
  end

  // Register copies to the protocol engine
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_own_station <= 8'h00;
      o_probe_node <= 8'h00;
    end else begin
      o_own_station <= own_station;
      o_probe_node <= probe_node;
    end
  end

endmodule

// ===== test/init_timing_checker_assertions.sv
// Port assertions for the init/timing block
`timescale 1ns/10ps
`include "init_timing_cfg.svh"

module init_timing_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_line_idle,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_interrupt_out_n,
  input wire init_timing_pkg::ram_wr_t o_ram_wr,
  input wire logic o_oversample_clock,
  input wire logic [7:0] o_own_station,
  input wire logic o_cmd_valid
);
  import init_timing_pkg::*;

  ahb_phase_t aph;
  logic bypass;
  logic ef;
  logic own_zero;
  logic succ_rd;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ----------
  // Shadows of address phase and control bits
  // ----------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aph <= '0;
    end else begin
      aph <= '{valid: i_hsel && i_hready && i_htrans[1], write: i_hwrite, addr: i_haddr[7:0]};
    end
  end

  // Host-written mode bits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bypass <= 1'b0;
      ef <= 1'b0;
    end else if (aph.valid && aph.write && aph.addr == `OFS_CONTROL) begin
      bypass <= i_hwdata[`CTL_SYNC_WAIT_BYPASS];
      ef <= i_hwdata[`CTL_ENHANCED_TIMING];
    end
  end

  // Zero station write, successor read
  assign own_zero = aph.valid && aph.write && aph.addr == `OFS_OWN_STATION
                    && i_hwdata[7:0] == 8'h00;
  assign succ_rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite
                   && i_haddr[7:0] == `OFS_SUCCESSOR_NODE;

  // ----------
  // Assertions
  // ----------
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus not okay");
  a_init_pair: assert property (
    o_ram_wr.we && o_ram_wr.addr == `INIT_ADDR0 |-> o_ram_wr.data == `INIT_PATTERN
    ##1 o_ram_wr.we && o_ram_wr.addr == `INIT_ADDR1 && o_ram_wr.data == o_own_station)
    else $error("init pair wrong");
  a_wait_idle: assert property (
    o_ram_wr.we && o_ram_wr.addr == `INIT_ADDR0 && !bypass
    |-> $past(i_line_idle, 1) || $past(i_line_idle, 2) || $past(i_line_idle, 3))
    else $error("init while busy");
  a_zero_quiet: assert property (own_zero |=> !o_ram_wr.we [*8])
    else $error("init after zero ID");
  a_cmd_spaced: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("commands too close");
  a_int_hold: assert property ($rose(o_interrupt_out_n) |-> o_interrupt_out_n [*5])
    else $error("int disable short");
  a_int_release: assert property (
    !o_interrupt_out_n && succ_rd |-> ##[1:3] o_interrupt_out_n)
    else $error("int not released");
  a_osc_sync: assert property (
    ef && $changed(o_oversample_clock) |=> $stable(o_oversample_clock) [*7])
    else $error("prescaler glitch");

  // Main scenarios reached
  c_init: cover property (o_ram_wr.we && o_ram_wr.addr == `INIT_ADDR1);
  c_int: cover property ($rose(o_interrupt_out_n));
  c_cmd: cover property (o_cmd_valid ##[1:4] o_cmd_valid);
endmodule

bind init_and_timing_refinements init_timing_checker u_chk (
  .i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready,
  .i_line_idle, .o_hreadyout, .o_hresp, .o_interrupt_out_n, .o_ram_wr,
  .o_oversample_clock, .o_own_station, .o_cmd_valid
);

// ===== test/ahb_host_model.sv
// AHB-Lite host model
`timescale 1ns/10ps

module ahb_host_model (
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata
);
  // Bus idle at time zero
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h00000000;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h00000000;
  end

  // One word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    o_hsel <= 1'b1;
    o_haddr <= {24'h000000, a};
    o_htrans <= 2'b10;
    o_hwrite <= w;
    // Address phase until ready
    do begin
      @(posedge i_clk);
      n++;
    end while (i_hready !== 1'b1 && n < 50);
    o_hsel <= 1'b0;
    o_htrans <= 2'b00;
    o_hwdata <= d;
    // Data phase until ready
    do begin
      @(posedge i_clk);
      n++;
    end while (i_hready !== 1'b1 && n < 100);
    q = i_hrdata;
    if (n >= 100) begin
      init_and_timing_refinements_tb_top.end_of_test(1'b1);
    end
  endtask
endmodule

// ===== test/init_and_timing_refinements_tb_top.sv
// Bench for the init/timing block
`timescale 1ns/10ps
`include "init_timing_cfg.svh"

module init_and_timing_refinements_tb_top;
  import init_timing_pkg::*;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic line_idle = 1'b1;
  logic ta_pulse = 1'b0;
  logic coll_v = 1'b0;
  logic [7:0] coll_id = 8'h00;
  logic hsel, hwrite, hready, hresp, int_n, osc, cmd_v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] own, probe, cmd_code, q;
  ram_wr_t ram_wr;
  row_t rows [8];
  int errors = 0;
  int checked = 0;
  int we_n = 0;
  int cmd_n = 0;
  int hp;

  // ----------
  // Clock, design and host
  // ----------
  initial begin
    forever #25 clk = ~clk;
  end

  init_and_timing_refinements dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .i_line_idle(line_idle), .i_ta_set_pulse(ta_pulse), .i_ri_set_pulse(1'b0),
    .i_successor_node(8'h3C), .i_collision_valid(coll_v), .i_collision_id(coll_id),
    .i_probe_answer(1'b0), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_interrupt_out_n(int_n), .o_ram_wr(ram_wr), .o_oversample_clock(osc),
    .o_own_station(own), .o_probe_node(probe), .o_cmd_valid(cmd_v), .o_cmd_code(cmd_code)
  );

  ahb_host_model host (
    .i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata)
  );

  // Count init writes and commands
  always @(negedge clk) begin
    if (ram_wr.we === 1'b1) we_n++;
    if (cmd_v === 1'b1) cmd_n++;
  end

  // ----------
  // Tasks
  // ----------
  task automatic end_of_test(input bit tmo);
    if (tmo) errors++;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, {24'h000000, d}, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h00000000, r);
    d = r[7:0];
  endtask

  // Bounded wait for interrupt level
  task automatic wait_int(input logic v);
    int n;
    n = 0;
    while (int_n !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) end_of_test(1'b1);
  endtask

  // Station ID write, init writes within 96 us
  task automatic run_init(input logic [7:0] id, input logic idle);
    int n;
    int base;
    n = 0;
    base = we_n;
    wr(`OFS_OWN_STATION, id);
    line_idle <= idle;
    while (we_n < base + 2 && n < 1920) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1920) end_of_test(1'b1);
    rd(`OFS_RAM0, q);
    cmp8(q, `INIT_PATTERN);
    rd(`OFS_RAM1, q);
    cmp8(q, id);
  endtask

  // Two back-to-back commands, count accepted
  task automatic two_cmds(input logic [7:0] ctl, input logic p, input logic [7:0] c,
                          input logic [7:0] e);
    int base;
    wr(`OFS_CONTROL, ctl);
    ta_pulse <= p;
    repeat (40) @(posedge clk);
    base = cmd_n;
    wr(`OFS_COMMAND, c);
    wr(`OFS_COMMAND, c);
    repeat (40) @(posedge clk);
    ta_pulse <= 1'b0;
    cmp8(8'(cmd_n - base), e);
  endtask

  // Oversample half period, partial ones skipped
  task automatic half(output int c);
    logic v;
    for (int k = 0; k < 3; k++) begin
      v = osc;
      c = 0;
      while (osc === v && c < 300) begin
        @(negedge clk);
        c++;
      end
    end
    if (c >= 300) end_of_test(1'b1);
  endtask

  // ----------
  // Main sequence
  // ----------
  initial begin
    rows = '{
      '{1'b0, `OFS_STATUS, 8'h00, 8'h03},
      '{1'b0, `OFS_CONTROL, 8'h00, 8'h00},
      '{1'b1, `OFS_REVISION, 8'h00, 8'h00},
      '{1'b1, `OFS_REVISION, 8'hC0, 8'hC5},
      '{1'b1, `OFS_PROBE_NODE, 8'h5A, 8'h5A},
      '{1'b1, 8'h40, 8'hFF, 8'h00},
      '{1'b1, `OFS_COLLISION_NODE, 8'h77, 8'h00},
      '{1'b1, `OFS_MASK, 8'h0B, 8'h0B}
    };
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wd);
      rd(rows[i].addr, q);
      cmp8(q, rows[i].exp);
    end
    cmp8(probe, 8'h5A);
    // Clearing actions release the interrupt
    for (int k = 0; k < 3; k++) begin
      wait_int(1'b0);
      if (k == 0) rd(`OFS_SUCCESSOR_NODE, q);
      else wr(`OFS_COMMAND, k == 1 ? `CMD_CLEAR_TXRX_INT : `CMD_CLEAR_FLAG);
      repeat (2) @(negedge clk);
      cmp8({7'h0, int_n}, 8'h01);
    end
    wr(`OFS_MASK, 8'h00);
    // Busy line stalls init
    line_idle <= 1'b0;
    wr(`OFS_OWN_STATION, 8'h2A);
    repeat (30) @(posedge clk);
    cmp8(8'(we_n), 8'h00);
    run_init(8'h2A, 1'b1);
    // Bypass: init with the line busy
    wr(`OFS_CONTROL, 8'h01);
    run_init(8'h33, 1'b0);
    // Enhanced zero-ID soft reset clears mask
    wr(`OFS_CONTROL, 8'h03);
    wr(`OFS_MASK, 8'h0B);
    wr(`OFS_OWN_STATION, 8'h00);
    rd(`OFS_MASK, q);
    cmp8(q, 8'h00);
    rd(`OFS_STATUS, q);
    cmp8(q & 8'h03, 8'h03);
    // Collision value cleared by a probe write
    @(posedge clk);
    coll_id <= 8'h44;
    coll_v <= 1'b1;
    @(posedge clk);
    coll_v <= 1'b0;
    rd(`OFS_COLLISION_NODE, q);
    cmp8(q, 8'h44);
    wr(`OFS_PROBE_NODE, 8'h12);
    rd(`OFS_COLLISION_NODE, q);
    cmp8(q, 8'h00);
    // Legacy soft reset keeps mask
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_MASK, 8'h0B);
    wr(`OFS_CONTROL, 8'h04);
    wr(`OFS_CONTROL, 8'h00);
    rd(`OFS_MASK, q);
    cmp8(q, 8'h0B);
    wr(`OFS_MASK, 8'h00);
    // Command spacing and enable prohibition
    two_cmds(8'h03, 1'b0, `CMD_CLEAR_FLAG, 8'h02);
    two_cmds(8'h00, 1'b0, `CMD_CLEAR_FLAG, 8'h01);
    rd(`OFS_STATUS, q);
    cmp8({7'h0, q[`ST_CMD_REFUSED]}, 8'h01);
    two_cmds(8'h00, 1'b1, `CMD_ENABLE_TX, 8'h00);
    two_cmds(8'h03, 1'b1, `CMD_ENABLE_TX, 8'h02);
    cmp8(cmd_code, `CMD_ENABLE_TX);
    rd(`OFS_STATUS, q);
    cmp8({7'h0, q[`ST_TA]}, 8'h01);
    // Prescale select sets the oversample rate
    for (int s = 0; s < 3; s++) begin
      wr(`OFS_CONTROL, {1'b0, 3'(s), 4'h3});
      half(hp);
      cmp8(8'(hp), 8'(`OS_DIV_BASE << s));
    end
    end_of_test(1'b0);
  end

  // Hang guard
  initial begin
    #4000000;
    end_of_test(1'b1);
  end
endmodule
